// *** verilog/msq_params.svh ***
// Constants of the sequential muting block: codes, offsets, timing.
// Assumes inclusion by bare name; definitions only.
`ifndef MSQ_PARAMS_SVH
`define MSQ_PARAMS_SVH
`define MSQ_CLK_NS          8
`define MSQ_MS_NS           1000000
`define MSQ_TICK_CYCLES     (`MSQ_MS_NS / `MSQ_CLK_NS)
`define MSQ_LIMIT_MAX_MIN   10
`define MSQ_LIMIT_MAX_MS    (`MSQ_LIMIT_MAX_MIN * 60 * 1000)
`define MSQ_OFS_CTRL        8'h00
`define MSQ_OFS_LIMIT       8'h04
`define MSQ_OFS_STATUS      8'h08
`define MSQ_CTRL_EN_BIT     0
`define MSQ_CTRL_PERMIT_BIT 1
`define MSQ_CTRL_RST        32'h0000_0000
`define MSQ_LIMIT_RST       32'h0000_0000
`define MSQ_ST_READY_BIT    16
`define MSQ_ST_PROT_BIT     17
`define MSQ_ST_MUTE_BIT     18
`define MSQ_ST_ERR_BIT      19
`define MSQ_ST_SENS_LSB     20
`define MSQ_RESP_OKAY       2'b00
`define MSQ_RESP_SLVERR     2'b10
`define MSQ_DC_IDLE         16'h0000
`define MSQ_DC_FREE         16'h8000
`define MSQ_DC_INIT         16'h8001
`define MSQ_DC_DEMAND       16'h8002
`define MSQ_DC_WAIT         16'h8003
`define MSQ_DC_FWD_START    16'h8011
`define MSQ_DC_FWD_ACT      16'h8012
`define MSQ_DC_BWD_START    16'h8122
`define MSQ_DC_BWD_ACT      16'h8112
`define MSQ_DC_ERR_RST1     16'hC001
`define MSQ_DC_ERR_RST2     16'hC002
`define MSQ_DC_ERR_LAMP     16'hC003
`define MSQ_DC_ERR_PARAM    16'hC005
`define MSQ_DC_ERR_TIMER    16'hC006
`define MSQ_SEQ_HI          4'hC
`define MSQ_SEQ_LO          4'h4
`define MSQ_NIB_FREE        4'h0
`define MSQ_NIB_FWD_START   4'h1
`define MSQ_NIB_FWD_ACT     4'h2
`define MSQ_NIB_BWD_START   4'h3
`define MSQ_NIB_BWD_ACT     4'h4
`define MSQ_NIB_NOPERMIT    4'hF
`endif

// *** verilog/msq_pkg.sv ***
// Types shared by the sequential muting block.
// Assumes msq_params.svh supplies all numeric constants.
package msq_pkg;
	typedef enum logic [3:0] {
		MSQ_IDLE, MSQ_INIT, MSQ_WAIT, MSQ_FREE, MSQ_DEMAND,
		MSQ_FWD_START, MSQ_FWD_ACT, MSQ_BWD_START, MSQ_BWD_ACT,
		MSQ_ERR_RST1, MSQ_ERR_RST2, MSQ_ERR_LAMP, MSQ_ERR_SEQ,
		MSQ_ERR_PARAM, MSQ_ERR_TIMER
	} msq_state_e;
endpackage

// *** verilog/msq_axil_regs.sv ***
// AXI4-Lite slave: control, time limit and read-only status words.
// Assumes a single clock, synchronous active-high reset.
`timescale 1ns/1ps
`include "msq_params.svh"
module msq_axil_regs import msq_pkg::*; #(
	parameter int ADDR_W = 8
) (
	// Clock and reset
	input  wire logic              ref_clk,
	input  wire logic              sys_rst,
	// Write address, data and response
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	// Read
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	// Register contents
	output logic [31:0]            ctrl_q,
	output logic [31:0]            limit_q,
	input  wire logic [31:0]       status
);
	logic              aw_got_q;
	logic              w_got_q;
	logic [ADDR_W-1:0] awaddr_q;
	logic [31:0]       wdata_q;
	logic [3:0]        wstrb_q;
	wire        do_write = aw_got_q & w_got_q & ~s_axi_bvalid;
	wire        hit_ctrl = awaddr_q == ADDR_W'(`MSQ_OFS_CTRL);
	wire        hit_lim  = awaddr_q == ADDR_W'(`MSQ_OFS_LIMIT);
	wire        rd_ctrl  = s_axi_araddr == ADDR_W'(`MSQ_OFS_CTRL);
	wire        rd_lim   = s_axi_araddr == ADDR_W'(`MSQ_OFS_LIMIT);
	wire        rd_stat  = s_axi_araddr == ADDR_W'(`MSQ_OFS_STATUS);
	wire [31:0] wmask    = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
	wire [31:0] rd_word  = rd_ctrl ? ctrl_q : rd_lim ? limit_q : rd_stat ? status : 32'h0000_0000;
	assign s_axi_awready = ~aw_got_q;
	assign s_axi_wready  = ~w_got_q;
	assign s_axi_arready = ~s_axi_rvalid;
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			aw_got_q     <= 1'b0;
			w_got_q      <= 1'b0;
			awaddr_q     <= '0;
			wdata_q      <= '0;
			wstrb_q      <= '0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `MSQ_RESP_OKAY;
			ctrl_q       <= `MSQ_CTRL_RST;
			limit_q      <= `MSQ_LIMIT_RST;
		end else begin
			if (s_axi_awvalid & ~aw_got_q) begin
				aw_got_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid & ~w_got_q) begin
				w_got_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_got_q     <= 1'b0;
				w_got_q      <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (hit_ctrl | hit_lim) ? `MSQ_RESP_OKAY : `MSQ_RESP_SLVERR;
				if (hit_ctrl)
					ctrl_q <= (ctrl_q & ~wmask) | (wdata_q & wmask);
				if (hit_lim)
					limit_q <= (limit_q & ~wmask) | (wdata_q & wmask);
			end else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= '0;
			s_axi_rresp  <= `MSQ_RESP_OKAY;
		end else if (s_axi_arvalid & ~s_axi_rvalid) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_word;
			s_axi_rresp  <= (rd_ctrl | rd_lim | rd_stat) ? `MSQ_RESP_OKAY : `MSQ_RESP_SLVERR;
		end else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end
endmodule // msq_axil_regs

// *** verilog/msq_muting_fsm.sv ***
// Sequential four-sensor muting controller for a protective light curtain.
// Assumes sensor, lamp and reset pins synchronous to ref_clk; registers over AXI4-Lite.
//
// Contract
// - Free to forward start on permit, a1 rising, others idle; timer starts.
// - Forward start to forward active on permit, a1 held, a2 rising, b idle.
// - Forward active to free when a idle, b1 falls, b2 active; timer stops.
// - Free to backward start on permit, b2 rising, others idle; timer starts.
// - Backward start to backward active on permit, a idle, b1 rising, b2 active.
// - Backward active to free when a1 active, a2 falls, b idle; timer stops.
// - Free: error on start without permit, a2 or b1 active, a1 with b2.
// - Forward start: error on permit low, a1 low, b1 or b2 active.
// - Forward active: error on a1 rising, a2 rising or b2 falling.
// - Backward start: error on permit low, a1 or a2 active, b2 low.
// - Backward active: error on a1 falling, b1 rising or b2 rising.
// - Block disable forces idle from any state, above everything else.
// - Muting states: sequence, timer, safety demand, lamp, then normal moves; active states skip demand, start states and free have no timer.
// - Errors drop protective and muting outputs, raise error, keep ready, give code.
// - Leave errors only after cause clears and a fresh reset pulse; reset errors C001 and C002 leave on reset release alone.
// - Reset already high entering init gives C001, entering wait gives C002.
// - Lamp failure enters lamp error with code C003.
// - Sequence code is C, state nibble, sensor snapshot, then 4.
// - State nibble 0,1,2,3,4 per muting state, F for start without permit.
// - Time limit below zero or above ten minutes gives C005.
// - Muting-active time beyond the limit gives C006.
// - Free drives ready and protective high, muting and error low.
// - Forward active drives ready, protective and muting high, error low.
//
// Our own choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "msq_params.svh"
module msq_muting_fsm import msq_pkg::*; #(
	parameter int ADDR_W      = 8,
	parameter int TICK_CYCLES = `MSQ_TICK_CYCLES
) (
	// Clock and reset
	input  wire logic              ref_clk,
	input  wire logic              sys_rst,
	// AXI4-Lite write
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	// AXI4-Lite read
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	// Field inputs
	input  wire logic              sensor_a1,
	input  wire logic              sensor_a2,
	input  wire logic              sensor_b1,
	input  wire logic              sensor_b2,
	input  wire logic              protective_device_in,
	input  wire logic              lamp_ok,
	input  wire logic              operator_reset,
	// Field outputs
	output logic                   ready,
	output logic                   protective_device_out,
	output logic                   muting_active_flag,
	output logic                   error,
	output logic [15:0]            diagnostic_code
);
	msq_state_e  state_q;
	msq_state_e  state_d;
	msq_state_e  last_q;
	logic [31:0] ctrl_q;
	logic [31:0] limit_q;
	logic [31:0] status;
	logic [3:0]  sens_q;
	logic        rst_q;
	logic        rst_old_q;
	logic [31:0] tick_cnt_q;
	logic [30:0] elapsed_q;
	logic [15:0] seq_code_q;
	logic [15:0] seq_code_d;
	logic [3:0]  seq_nib;
	logic [15:0] code_d;
	logic        ready_d;
	logic        prot_d;
	logic        mute_d;
	logic        err_d;

	msq_axil_regs #(
		.ADDR_W (ADDR_W)
	) u_regs (
		.ref_clk       (ref_clk),
		.sys_rst       (sys_rst),
		.s_axi_awaddr  (s_axi_awaddr),
		.s_axi_awvalid (s_axi_awvalid),
		.s_axi_awready (s_axi_awready),
		.s_axi_wdata   (s_axi_wdata),
		.s_axi_wstrb   (s_axi_wstrb),
		.s_axi_wvalid  (s_axi_wvalid),
		.s_axi_wready  (s_axi_wready),
		.s_axi_bresp   (s_axi_bresp),
		.s_axi_bvalid  (s_axi_bvalid),
		.s_axi_bready  (s_axi_bready),
		.s_axi_araddr  (s_axi_araddr),
		.s_axi_arvalid (s_axi_arvalid),
		.s_axi_arready (s_axi_arready),
		.s_axi_rdata   (s_axi_rdata),
		.s_axi_rresp   (s_axi_rresp),
		.s_axi_rvalid  (s_axi_rvalid),
		.s_axi_rready  (s_axi_rready),
		.ctrl_q        (ctrl_q),
		.limit_q       (limit_q),
		.status        (status)
	);

	wire block_enable  = ctrl_q[`MSQ_CTRL_EN_BIT];
	wire muting_permit = ctrl_q[`MSQ_CTRL_PERMIT_BIT];
	wire [3:0] sens    = {sensor_b2, sensor_b1, sensor_a2, sensor_a1};
	wire [3:0] rise;
	wire [3:0] fall;

	// Edges against last clock's sample, one stage per sensor
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_edge
			always_ff @(posedge ref_clk) begin
				if (sys_rst)
					sens_q[gi] <= 1'b0;
				else
					sens_q[gi] <= sens[gi];
			end
			assign rise[gi] = sens[gi] & ~sens_q[gi];
			assign fall[gi] = ~sens[gi] & sens_q[gi];
		end
	endgenerate

	wire a1 = sens[0];
	wire a2 = sens[1];
	wire b1 = sens[2];
	wire b2 = sens[3];
	wire rst_rise  = operator_reset & ~rst_q;
	wire entry     = state_q != last_q;
	// Stale only if held over two samples; the edge that caused entry is not stale
	wire rst_stale = entry & rst_q & rst_old_q;
	wire demand    = ~protective_device_in;
	wire lamp_bad  = ~lamp_ok;

	// Normal muting moves
	wire go_fwd_start = muting_permit & rise[0] & ~a2 & ~b1 & ~b2;
	wire go_fwd_act   = muting_permit & a1 & rise[1] & ~b1 & ~b2;
	wire go_fwd_end   = ~a1 & ~a2 & fall[2] & b2;
	wire go_bwd_start = muting_permit & ~a1 & ~a2 & ~b1 & rise[3];
	wire go_bwd_act   = muting_permit & ~a1 & ~a2 & rise[2] & b2;
	wire go_bwd_end   = a1 & fall[1] & ~b1 & ~b2;

	// Illegal sequences per muting state
	wire nopermit_start = ~muting_permit & (rise[0] | rise[3]);
	wire seq_free  = nopermit_start | a2 | b1 | (a1 & b2);
	wire seq_fwd_s = ~muting_permit | ~a1 | b1 | b2;
	wire seq_fwd_a = rise[0] | rise[1] | fall[3];
	wire seq_bwd_s = ~muting_permit | a1 | a2 | ~b2;
	wire seq_bwd_a = fall[0] | rise[2] | rise[3];

	// Limit is signed so a negative write is caught, not wrapped
	wire param_bad = ($signed(limit_q) < 0) | ($signed(limit_q) > `MSQ_LIMIT_MAX_MS);
	wire timing    = (state_q == MSQ_FWD_START) | (state_q == MSQ_FWD_ACT) |
	                 (state_q == MSQ_BWD_START) | (state_q == MSQ_BWD_ACT);
	wire counting  = (state_q == MSQ_FWD_ACT) | (state_q == MSQ_BWD_ACT);
	wire tick      = tick_cnt_q == 32'h0000_0000;
	wire timer_over = counting & ({1'b0, elapsed_q} > limit_q);
	wire timer_start = (state_q == MSQ_FREE) & ((state_d == MSQ_FWD_START) | (state_d == MSQ_BWD_START));
	wire sens_clear = sens == 4'h0;

	// Next state
	always_comb begin
		state_d = state_q;
		seq_nib = `MSQ_NIB_FREE;
		case (state_q)
			MSQ_IDLE: begin
				if (block_enable)
					state_d = MSQ_INIT;
			end
			MSQ_INIT: begin
				if (rst_stale)
					state_d = MSQ_ERR_RST1;
				else if (rst_rise & protective_device_in)
					state_d = MSQ_FREE;
			end
			MSQ_WAIT: begin
				if (rst_stale)
					state_d = MSQ_ERR_RST2;
				else if (demand)
					state_d = MSQ_DEMAND;
				else if (rst_rise)
					state_d = MSQ_FREE;
			end
			MSQ_DEMAND: begin
				if (protective_device_in)
					state_d = MSQ_WAIT;
			end
			MSQ_FREE: begin
				seq_nib = nopermit_start ? `MSQ_NIB_NOPERMIT : `MSQ_NIB_FREE;
				if (seq_free)
					state_d = MSQ_ERR_SEQ;
				else if (demand)
					state_d = MSQ_DEMAND;
				else if (lamp_bad)
					state_d = MSQ_ERR_LAMP;
				else if (go_fwd_start)
					state_d = MSQ_FWD_START;
				else if (go_bwd_start)
					state_d = MSQ_BWD_START;
			end
			MSQ_FWD_START: begin
				seq_nib = `MSQ_NIB_FWD_START;
				if (seq_fwd_s)
					state_d = MSQ_ERR_SEQ;
				else if (demand)
					state_d = MSQ_DEMAND;
				else if (lamp_bad)
					state_d = MSQ_ERR_LAMP;
				else if (go_fwd_act)
					state_d = MSQ_FWD_ACT;
			end
			MSQ_FWD_ACT: begin
				seq_nib = `MSQ_NIB_FWD_ACT;
				if (seq_fwd_a)
					state_d = MSQ_ERR_SEQ;
				else if (timer_over)
					state_d = MSQ_ERR_TIMER;
				else if (lamp_bad)
					state_d = MSQ_ERR_LAMP;
				else if (go_fwd_end)
					state_d = MSQ_FREE;
			end
			MSQ_BWD_START: begin
				seq_nib = `MSQ_NIB_BWD_START;
				if (seq_bwd_s)
					state_d = MSQ_ERR_SEQ;
				else if (demand)
					state_d = MSQ_DEMAND;
				else if (lamp_bad)
					state_d = MSQ_ERR_LAMP;
				else if (go_bwd_act)
					state_d = MSQ_BWD_ACT;
			end
			MSQ_BWD_ACT: begin
				seq_nib = `MSQ_NIB_BWD_ACT;
				if (seq_bwd_a)
					state_d = MSQ_ERR_SEQ;
				else if (timer_over)
					state_d = MSQ_ERR_TIMER;
				else if (lamp_bad)
					state_d = MSQ_ERR_LAMP;
				else if (go_bwd_end)
					state_d = MSQ_FREE;
			end
			// Reset errors clear once reset is released; the fresh edge is then judged again
			MSQ_ERR_RST1: begin
				if (~operator_reset)
					state_d = MSQ_INIT;
			end
			MSQ_ERR_RST2: begin
				if (~operator_reset)
					state_d = MSQ_WAIT;
			end
			MSQ_ERR_LAMP: begin
				if (lamp_ok & rst_rise)
					state_d = MSQ_WAIT;
			end
			MSQ_ERR_SEQ, MSQ_ERR_TIMER: begin
				if (sens_clear & rst_rise)
					state_d = MSQ_WAIT;
			end
			MSQ_ERR_PARAM: begin
				if (~param_bad & rst_rise)
					state_d = MSQ_WAIT;
			end
			default: state_d = MSQ_IDLE;
		endcase
		// Parameter check sits just below disable so a bad limit never times a passage
		if (param_bad & (state_q != MSQ_IDLE) & (state_q != MSQ_ERR_PARAM))
			state_d = MSQ_ERR_PARAM;
		if (~block_enable)
			state_d = MSQ_IDLE;
	end

	// Snapshot taken in the cycle the sequence fault is seen
	assign seq_code_d = ((state_d == MSQ_ERR_SEQ) & (state_q != MSQ_ERR_SEQ)) ?
	                    {`MSQ_SEQ_HI, seq_nib, sens, `MSQ_SEQ_LO} : seq_code_q;

	// Output decode from the next state, registered below
	always_comb begin
		ready_d = 1'b1;
		prot_d  = 1'b0;
		mute_d  = 1'b0;
		err_d   = 1'b1;
		code_d  = `MSQ_DC_IDLE;
		case (state_d)
			MSQ_IDLE: begin
				ready_d = 1'b0;
				err_d   = 1'b0;
			end
			MSQ_INIT: begin
				err_d  = 1'b0;
				code_d = `MSQ_DC_INIT;
			end
			MSQ_WAIT: begin
				err_d  = 1'b0;
				code_d = `MSQ_DC_WAIT;
			end
			MSQ_DEMAND: begin
				err_d  = 1'b0;
				code_d = `MSQ_DC_DEMAND;
			end
			MSQ_FREE: begin
				prot_d = 1'b1;
				err_d  = 1'b0;
				code_d = `MSQ_DC_FREE;
			end
			MSQ_FWD_START: begin
				prot_d = 1'b1;
				err_d  = 1'b0;
				code_d = `MSQ_DC_FWD_START;
			end
			MSQ_FWD_ACT: begin
				prot_d = 1'b1;
				mute_d = 1'b1;
				err_d  = 1'b0;
				code_d = `MSQ_DC_FWD_ACT;
			end
			MSQ_BWD_START: begin
				prot_d = 1'b1;
				err_d  = 1'b0;
				code_d = `MSQ_DC_BWD_START;
			end
			MSQ_BWD_ACT: begin
				prot_d = 1'b1;
				mute_d = 1'b1;
				err_d  = 1'b0;
				code_d = `MSQ_DC_BWD_ACT;
			end
			MSQ_ERR_RST1:  code_d = `MSQ_DC_ERR_RST1;
			MSQ_ERR_RST2:  code_d = `MSQ_DC_ERR_RST2;
			MSQ_ERR_LAMP:  code_d = `MSQ_DC_ERR_LAMP;
			MSQ_ERR_SEQ:   code_d = seq_code_d;
			MSQ_ERR_PARAM: code_d = `MSQ_DC_ERR_PARAM;
			MSQ_ERR_TIMER: code_d = `MSQ_DC_ERR_TIMER;
			default:       code_d = `MSQ_DC_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			state_q    <= MSQ_IDLE;
			last_q     <= MSQ_IDLE;
			rst_q      <= 1'b0;
			rst_old_q  <= 1'b0;
			seq_code_q <= `MSQ_DC_IDLE;
		end else begin
			state_q    <= state_d;
			last_q     <= state_q;
			rst_q      <= operator_reset;
			rst_old_q  <= rst_q;
			seq_code_q <= seq_code_d;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			ready                 <= 1'b0;
			protective_device_out <= 1'b0;
			muting_active_flag    <= 1'b0;
			error                 <= 1'b0;
			diagnostic_code       <= `MSQ_DC_IDLE;
		end else begin
			ready                 <= ready_d;
			protective_device_out <= prot_d;
			muting_active_flag    <= mute_d;
			error                 <= err_d;
			diagnostic_code       <= code_d;
		end
	end

	// Millisecond enable; reloaded at start so the first tick is a full period
	always_ff @(posedge ref_clk) begin
		if (sys_rst | timer_start | ~timing | tick)
			tick_cnt_q <= 32'(TICK_CYCLES - 1);
		else
			tick_cnt_q <= tick_cnt_q - 32'h0000_0001;
	end

	// Elapsed muting time, counted only while muting is active
	always_ff @(posedge ref_clk) begin
		if (sys_rst | timer_start | ~timing)
			elapsed_q <= '0;
		else if (counting & tick & ~elapsed_q[30])
			elapsed_q <= elapsed_q + 31'h0000_0001;
	end

	assign status = {8'h00, sens, error, muting_active_flag, protective_device_out, ready, diagnostic_code};
endmodule // msq_muting_fsm

// *** testbench/msq_field_model.sv ***
// Field side model: muting sensors, light curtain output, lamp, operator.
// Assumes the bench sets the cmd_* levels at a rising edge of ref_clk.
`timescale 1ns/1ps
module msq_field_model (
	// Clock
	input  wire logic       ref_clk,
	// Bench commands
	input  wire logic [3:0] cmd_sens,
	input  wire logic       cmd_curtain,
	input  wire logic       cmd_lamp,
	input  wire logic       cmd_ack,
	// Lines into the block
	output logic            sensor_a1,
	output logic            sensor_a2,
	output logic            sensor_b1,
	output logic            sensor_b2,
	output logic            protective_device_in,
	output logic            lamp_ok,
	output logic            operator_reset
);
	initial {sensor_b2, sensor_b1, sensor_a2, sensor_a1, protective_device_in, lamp_ok, operator_reset} = 7'h06;
	// One register stage, as a real field input would add
	always @(posedge ref_clk) begin
		{sensor_b2, sensor_b1, sensor_a2, sensor_a1} <= cmd_sens;
		protective_device_in <= cmd_curtain;
		lamp_ok <= cmd_lamp;
		// Acknowledge only when asked; held levels model operator misuse
		operator_reset <= cmd_ack;
	end
endmodule // msq_field_model

// *** testbench/msq_monitor.sv ***
// Concurrent checks on the field ports of the muting block.
// Assumes one clock, ref_clk, and synchronous active-high sys_rst.
`timescale 1ns/1ps
module msq_monitor (
	// Clock and reset
	input wire logic        ref_clk,
	input wire logic        sys_rst,
	// Field inputs
	input wire logic        sensor_a1,
	input wire logic        sensor_a2,
	input wire logic        sensor_b1,
	input wire logic        sensor_b2,
	input wire logic        protective_device_in,
	input wire logic        lamp_ok,
	input wire logic        operator_reset,
	// Field outputs
	input wire logic        ready,
	input wire logic        protective_device_out,
	input wire logic        muting_active_flag,
	input wire logic        error,
	input wire logic [15:0] diagnostic_code
);
	wire logic [3:0]  sens = {sensor_b2, sensor_b1, sensor_a2, sensor_a1};
	wire logic [15:0] dc   = diagnostic_code;
	// Disable and parameter error outrank everything the checks expect
	wire logic        pre  = (dc == 16'hC005) || (dc == 16'h0000);
	wire logic        rerr = (dc == 16'hC001) || (dc == 16'hC002);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	free_outputs_a: assert property (dc == 16'h8000 |->
		ready && protective_device_out && !muting_active_flag && !error)
		else $error("free state outputs wrong");
	fwd_outputs_a: assert property (dc == 16'h8012 |->
		ready && protective_device_out && muting_active_flag && !error)
		else $error("forward active outputs wrong");
	error_outputs_a: assert property (error |->
		ready && !protective_device_out && !muting_active_flag && dc[15:12] == 4'hC)
		else $error("error outputs wrong");
	fwd_start_a: assert property (dc == 16'h8000 && $rose(sensor_a1) && sens[3:1] == 3'h0 && lamp_ok
		&& protective_device_in |=> dc == 16'h8011 || dc == 16'hCF14 || pre) else $error("forward start missed");
	fwd_end_a: assert property (dc == 16'h8012 && sens[1:0] == 2'h0 && $fell(sensor_b1) && sensor_b2
		&& lamp_ok |=> dc == 16'h8000 || dc == 16'hC006 || pre) else $error("forward end missed");
	seq_code_a: assert property (dc == 16'h8012 && ($rose(sensor_a1) || $rose(sensor_a2))
		|=> dc == {8'hC2, $past(sens), 4'h4} || pre) else $error("forward active sequence code wrong");
	free_seq_a: assert property (dc == 16'h8000 && (sensor_a2 || sensor_b1) && !$rose(sensor_a1)
		&& !$rose(sensor_b2) |=> dc == {8'hC0, $past(sens), 4'h4} || pre)
		else $error("free state sequence code wrong");
	lamp_err_a: assert property (dc == 16'h8012 && !lamp_ok && $stable(sens)
		|=> dc == 16'hC003 || dc == 16'hC006 || pre) else $error("lamp failure missed");
	err_hold_a: assert property (error && !rerr && !$rose(operator_reset)
		|=> error || dc == 16'h0000) else $error("error left without reset");
	err_exit_a: assert property (error && !rerr ##1 !error && dc != 16'h0000
		|-> dc == 16'h8003) else $error("error exit not to wait");
endmodule // msq_monitor

bind msq_muting_fsm msq_monitor u_monitor (.*);

// *** testbench/tb.sv ***
// Self-checking bench: AXI4-Lite register tasks plus field sequences.
// Assumes msq_muting_fsm with a short tick and the field model beside it.
`timescale 1ns/1ps
`include "msq_params.svh"
`define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) begin mismatches++; \
	$display("ERROR %s expected %h seen %h", n, e, a); end end
module tb;
	logic        ref_clk = 1'b0, sys_rst = 1'b1;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0]  s_axi_wstrb = 4'hF, cmd_sens = 4'h0;
	logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        sensor_a1, sensor_a2, sensor_b1, sensor_b2, protective_device_in, lamp_ok, operator_reset;
	logic        ready, protective_device_out, muting_active_flag, error;
	logic [15:0] diagnostic_code;
	logic        cmd_curtain = 1, cmd_lamp = 1, cmd_ack = 0;
	int          mismatches = 0, total_checks = 0;
	logic [3:0]  seq_s [16] = '{4'h1, 4'h3, 4'h7, 4'hF, 4'hE, 4'hC, 4'h8, 4'h0,
		4'h8, 4'hC, 4'hE, 4'hF, 4'h7, 4'h3, 4'h1, 4'h0};
	logic [15:0] seq_c [16] = '{16'h8011, 16'h8012, 16'h8012, 16'h8012, 16'h8012, 16'h8012, 16'h8000, 16'h8000,
		16'h8122, 16'h8112, 16'h8112, 16'h8112, 16'h8112, 16'h8112, 16'h8000, 16'h8000};
	logic [31:0] bad_lim [2] = '{32'd600001, 32'hFFFF_FFFF};
	initial forever #4 ref_clk = ~ref_clk;
	msq_muting_fsm #(.TICK_CYCLES(10)) DUT (.*);
	msq_field_model u_field (.*);
	task automatic report_and_stop;
		if (mismatches == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		logic aw, w;
		aw = 0;
		w = 0;
		// One edge between calls, so a ready just dropped is never raised in the same step
		@(posedge ref_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		while (!(aw && w)) begin
			@(posedge ref_clk);
			if (s_axi_awvalid && s_axi_awready === 1'b1) begin
				aw = 1;
				s_axi_awvalid <= 0;
			end
			if (s_axi_wvalid && s_axi_wready === 1'b1) begin
				w = 1;
				s_axi_wvalid <= 0;
			end
		end
		do @(posedge ref_clk); while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 0;
		`CHK("bresp", e, s_axi_bresp)
	endtask
	task automatic axr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		@(posedge ref_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do @(posedge ref_clk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 0;
		do @(posedge ref_clk); while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 0;
		`CHK("rdata", d, s_axi_rdata)
		`CHK("rresp", e, s_axi_rresp)
	endtask
	// Four edges: model stage, block sample with output update, one spare, settled read
	task automatic step(input logic [3:0] s, input logic [15:0] c);
		cmd_sens <= s;
		repeat (4) @(posedge ref_clk);
		`CHK("diagnostic_code", c, diagnostic_code)
	endtask
	task automatic pulse(input logic [15:0] c);
		cmd_ack <= 1;
		repeat (4) @(posedge ref_clk);
		`CHK("diagnostic_code", c, diagnostic_code)
		cmd_ack <= 0;
		repeat (4) @(posedge ref_clk);
	endtask
	task automatic recov;
		pulse(16'h8003);
		pulse(16'h8000);
	endtask
	initial begin
		repeat (20000) @(posedge ref_clk);
		mismatches++;
		report_and_stop;
	end
	initial begin
		repeat (16) @(posedge ref_clk);
		sys_rst <= 0;
		@(posedge ref_clk);
		axr(`MSQ_OFS_STATUS, 32'h0, `MSQ_RESP_OKAY);
		axr(8'h0C, 32'h0, `MSQ_RESP_SLVERR);
		axw(`MSQ_OFS_STATUS, 32'h1, `MSQ_RESP_SLVERR);
		axw(`MSQ_OFS_LIMIT, 32'd100, `MSQ_RESP_OKAY);
		axr(`MSQ_OFS_LIMIT, 32'd100, `MSQ_RESP_OKAY);
		axw(`MSQ_OFS_CTRL, 32'h3, `MSQ_RESP_OKAY);
		step(4'h0, 16'h8001);
		pulse(16'h8000);
		for (int i = 0; i < 16; i++) step(seq_s[i], seq_c[i]);
		step(4'h1, 16'h8011);
		step(4'h3, 16'h8012);
		axr(`MSQ_OFS_STATUS, 32'h0037_8012, `MSQ_RESP_OKAY);
		step(4'h2, 16'h8012);
		step(4'h3, 16'hC234);
		axr(`MSQ_OFS_STATUS, 32'h0039_C234, `MSQ_RESP_OKAY);
		step(4'h0, 16'hC234);
		recov;
		axw(`MSQ_OFS_CTRL, 32'h1, `MSQ_RESP_OKAY);
		step(4'h1, 16'hCF14);
		axw(`MSQ_OFS_CTRL, 32'h3, `MSQ_RESP_OKAY);
		step(4'h0, 16'hCF14);
		recov;
		step(4'h2, 16'hC024);
		step(4'h0, 16'hC024);
		recov;
		step(4'h1, 16'h8011);
		axw(`MSQ_OFS_CTRL, 32'h1, `MSQ_RESP_OKAY);
		step(4'h1, 16'hC114);
		axw(`MSQ_OFS_CTRL, 32'h3, `MSQ_RESP_OKAY);
		step(4'h0, 16'hC114);
		recov;
		axw(`MSQ_OFS_LIMIT, 32'd2, `MSQ_RESP_OKAY);
		step(4'h1, 16'h8011);
		step(4'h3, 16'h8012);
		repeat (40) @(posedge ref_clk);
		`CHK("diagnostic_code", 16'hC006, diagnostic_code)
		step(4'h0, 16'hC006);
		recov;
		axw(`MSQ_OFS_LIMIT, 32'd100, `MSQ_RESP_OKAY);
		step(4'h1, 16'h8011);
		step(4'h3, 16'h8012);
		cmd_lamp <= 0;
		step(4'h3, 16'hC003);
		cmd_lamp <= 1;
		step(4'h0, 16'hC003);
		recov;
		cmd_curtain <= 0;
		step(4'h0, 16'h8002);
		cmd_curtain <= 1;
		step(4'h0, 16'h8003);
		pulse(16'h8000);
		foreach (bad_lim[i]) begin
			axw(`MSQ_OFS_LIMIT, bad_lim[i], `MSQ_RESP_OKAY);
			step(4'h0, 16'hC005);
			axw(`MSQ_OFS_LIMIT, 32'd100, `MSQ_RESP_OKAY);
			recov;
		end
		axw(`MSQ_OFS_CTRL, 32'h0, `MSQ_RESP_OKAY);
		step(4'h0, 16'h0000);
		cmd_ack <= 1;
		axw(`MSQ_OFS_CTRL, 32'h3, `MSQ_RESP_OKAY);
		step(4'h0, 16'hC001);
		cmd_ack <= 0;
		step(4'h0, 16'h8001);
		pulse(16'h8000);
		cmd_ack <= 1;
		cmd_curtain <= 0;
		step(4'h0, 16'h8002);
		cmd_curtain <= 1;
		step(4'h0, 16'hC002);
		cmd_ack <= 0;
		step(4'h0, 16'h8003);
		pulse(16'h8000);
		report_and_stop;
	end
endmodule // tb
